// >>> hw/lsi_pkg.sv
`default_nettype none
package lsi_pkg;
  // Register indices; the AXI byte address is four times the index
  localparam logic [7:0] IDX_IRQ_ENABLE    = 8'hc6;
  localparam logic [7:0] IDX_IRQ_FLAGS     = 8'hc7;
  localparam logic [7:0] IDX_KEYSTORE_CTRL = 8'hc8;
  localparam logic [7:0] IDX_LINK_OPTIONS  = 8'hc9;
  localparam logic [7:0] IDX_BLANK_COLOUR  = 8'hce;
  localparam logic [7:0] IDX_REMOTE_STATE  = 8'hd0;
  localparam logic [7:0] IDX_REMOTE_TARGET = 8'hd1;
  localparam logic [7:0] IDX_REMOTE_OFFSET = 8'hd2;
  localparam logic [7:0] IDX_REMOTE_DATA   = 8'hd3;

  // Event bit positions, shared by enable and flag registers
  localparam int BIT_GLOBAL      = 0;
  localparam int BIT_AUTH_OK     = 1;
  localparam int BIT_AUTH_FAIL   = 2;
  localparam int BIT_KEY_READY   = 3;
  localparam int BIT_LIST_READY  = 4;
  localparam int BIT_SINK_REQ    = 5;
  localparam int BIT_SINK_FOUND  = 6;
  localparam int BIT_ACCESS_DONE = 7;

  // Key-store control fields
  localparam int         BIT_CHECK_START = 2;
  localparam int         BIT_CHECK_DONE  = 6;
  localparam int         BIT_CHECK_OK    = 7;
  localparam logic [7:0] KEYSTORE_RW_MASK = 8'h23;

  // Remote access state fields
  localparam int BIT_FINISHED   = 0;
  localparam int BIT_ACKED      = 1;
  localparam int BIT_FAST_MODE  = 4;
  localparam int BIT_TO_DISABLE = 5;
  localparam int BIT_TO_SPEEDUP = 6;
  localparam int BIT_MASTER_RST = 7;
  localparam logic [7:0] REMOTE_CTL_MASK = 8'h70;

  localparam int BIT_WAIT_LOCK = 0;

  localparam logic [7:0] RST_ZERO  = 8'h00;
  localparam logic [7:0] RST_BLANK = 8'hff;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Idle bus timeout: least times, rounded up to cycles
  localparam int CLK_HZ          = 20_000_000;
  localparam int IDLE_TIMEOUT_MS = 1000;
  localparam int SPEEDUP_US      = 50;
  localparam int IDLE_CYCLES     = (CLK_HZ / 1000) * IDLE_TIMEOUT_MS;
  localparam int SPEEDUP_CYCLES  = (SPEEDUP_US * (CLK_HZ / 1000) + 999) / 1000;
endpackage : lsi_pkg
`default_nettype wire

// >>> hw/lsi_top.sv
// What this block does
// R01: Interrupt output only when global enable set
// R02: Global flag shows any enabled pending event
// R03: Access completion flags bit 7, enable 7
// R04: Receiver detect flag, optionally waits for lock
// R05: Remote receiver interrupt request flags bit 5
// R06: Key list ready flags bit 4
// R07: Receiver key ready flags bit 3
// R08: Authentication failure or loss flags bit 2
// R09: Authentication success flags bit 1
// R10: Verify bit starts key check, self-clears
// R11: Done flag set when key check finishes
// R12: Pass bit gives result, valid with done
// R13: Blank screen puts programmed byte on blue
// R14: Writing bit 7 resets remote bus master
// R15: Remote master frees idle bus after timeout
// R16: Speedup bit shortens idle timeout to 50us
// R17: Bit 4 selects fast or standard timing
// R18: Ack bit shows target acknowledged transfer
// R19: Finished bit set on completion, cleared on read/start
// R20: Target register holds address and direction
// R21: Data register carries write and read byte
// R22: Event flags stay until read, unless condition persists
// R23: Writing target register starts remote access
`timescale 1ns/1ps
`default_nettype none
module lsi_top #(
  parameter int IDLE_CYCLES = lsi_pkg::IDLE_CYCLES,
  parameter int ADDR_W      = 12
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_b,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  output logic                   o_irq,
  input  wire logic              i_sink_detect,
  input  wire logic              i_sink_lock,
  input  wire logic              i_sink_irq,
  input  wire logic              i_key_list_ready,
  input  wire logic              i_sink_key_ready,
  input  wire logic              i_auth_ok,
  input  wire logic              i_auth_fail,
  output logic                   o_keystore_check_req,
  input  wire logic              i_keystore_check_finish,
  input  wire logic              i_keystore_check_match,
  input  wire logic              i_blank_screen,
  input  wire logic [7:0]        i_video_blue,
  output logic [7:0]             o_blue_channel,
  output logic                   o_remote_start,
  output logic [6:0]             o_remote_target_addr,
  output logic                   o_remote_dir_sel,
  output logic [7:0]             o_remote_offset,
  output logic [7:0]             o_remote_data_byte,
  input  wire logic              i_remote_finish,
  input  wire logic              i_remote_acked,
  input  wire logic [7:0]        i_remote_rdata,
  output logic                   o_remote_master_reset,
  output logic                   o_fast_mode,
  input  wire logic              i_bus_activity,
  output logic                   o_idle_bus_free
);

  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    hit = (addr[ADDR_W-1:2] == {{(ADDR_W-10){1'b0}}, idx});
  endfunction : hit

  localparam int CNT_W = $clog2(IDLE_CYCLES + 1);

  logic [7:0]       irq_en_ff;
  logic [7:1]       flags_ff;
  logic [7:0]       keystore_ff;
  logic             wait_lock_ff;
  logic [7:0]       blank_ff;
  logic [7:0]       remote_ctl_ff;
  logic             finished_ff;
  logic             acked_ff;
  logic [7:0]       target_ff;
  logic [7:0]       offset_ff;
  logic [7:0]       data_ff;
  logic             auth_ok_q_ff;
  logic             start_ff;
  logic             master_rst_ff;
  logic             check_req_ff;
  logic [7:0]       blue_ff;
  logic [CNT_W-1:0] idle_cnt_ff;
  logic             bvalid_ff;
  logic [1:0]       bresp_ff;
  logic             rvalid_ff;
  logic [31:0]      rdata_ff;
  logic [1:0]       rresp_ff;

  // Write path: address and data are taken together, one beat per response
  wire       wr_take   = i_awvalid && i_wvalid && !bvalid_ff;
  wire       wr_lane   = wr_take && i_wstrb[0];
  wire [7:0] wbyte     = i_wdata[7:0];
  wire       wr_en     = wr_lane && hit(i_awaddr, lsi_pkg::IDX_IRQ_ENABLE);
  wire       wr_key    = wr_lane && hit(i_awaddr, lsi_pkg::IDX_KEYSTORE_CTRL);
  wire       wr_opt    = wr_lane && hit(i_awaddr, lsi_pkg::IDX_LINK_OPTIONS);
  wire       wr_blank  = wr_lane && hit(i_awaddr, lsi_pkg::IDX_BLANK_COLOUR);
  wire       wr_state  = wr_lane && hit(i_awaddr, lsi_pkg::IDX_REMOTE_STATE);
  wire       wr_target = wr_lane && hit(i_awaddr, lsi_pkg::IDX_REMOTE_TARGET);
  wire       wr_offset = wr_lane && hit(i_awaddr, lsi_pkg::IDX_REMOTE_OFFSET);
  wire       wr_data   = wr_lane && hit(i_awaddr, lsi_pkg::IDX_REMOTE_DATA);
  wire       wr_mapped = hit(i_awaddr, lsi_pkg::IDX_IRQ_ENABLE)
                      || hit(i_awaddr, lsi_pkg::IDX_IRQ_FLAGS)
                      || hit(i_awaddr, lsi_pkg::IDX_KEYSTORE_CTRL)
                      || hit(i_awaddr, lsi_pkg::IDX_LINK_OPTIONS)
                      || hit(i_awaddr, lsi_pkg::IDX_BLANK_COLOUR)
                      || hit(i_awaddr, lsi_pkg::IDX_REMOTE_STATE)
                      || hit(i_awaddr, lsi_pkg::IDX_REMOTE_TARGET)
                      || hit(i_awaddr, lsi_pkg::IDX_REMOTE_OFFSET)
                      || hit(i_awaddr, lsi_pkg::IDX_REMOTE_DATA);

  // Read path: one outstanding read, data registered
  wire rd_take  = i_arvalid && !rvalid_ff;
  wire rd_flags = rd_take && hit(i_araddr, lsi_pkg::IDX_IRQ_FLAGS);
  wire rd_state = rd_take && hit(i_araddr, lsi_pkg::IDX_REMOTE_STATE);

  // Events, sampled each cycle
  wire       found_cond = i_sink_detect && (!wait_lock_ff || i_sink_lock); // see R04
  wire       auth_lost  = auth_ok_q_ff && !i_auth_ok;
  wire [7:1] events     = {i_remote_finish,                                // see R03
                           found_cond,
                           i_sink_irq,                                     // see R05
                           i_key_list_ready,                               // see R06
                           i_sink_key_ready,                               // see R07
                           i_auth_fail || auth_lost,                       // see R08
                           i_auth_ok};                                     // see R09
  wire       any_enabled = |(flags_ff & irq_en_ff[7:1]);                   // see R02
  wire [7:0] flags_view  = {flags_ff, any_enabled};
  // Set wins over the read-clear so no event is lost
  wire [7:1] nxt_flags   = (rd_flags ? 7'h00 : flags_ff) | events;         // see R22

  wire       check_begin = wr_key && wbyte[lsi_pkg::BIT_CHECK_START]
                        && !keystore_ff[lsi_pkg::BIT_CHECK_START];          // see R10
  wire [7:0] state_view  = {1'b0, remote_ctl_ff[6:4], 2'b00, acked_ff, finished_ff};

  wire [7:0] rd_byte =
      hit(i_araddr, lsi_pkg::IDX_IRQ_ENABLE)    ? irq_en_ff :
      hit(i_araddr, lsi_pkg::IDX_IRQ_FLAGS)     ? flags_view :
      hit(i_araddr, lsi_pkg::IDX_KEYSTORE_CTRL) ? keystore_ff :
      hit(i_araddr, lsi_pkg::IDX_LINK_OPTIONS)  ? {7'h00, wait_lock_ff} :
      hit(i_araddr, lsi_pkg::IDX_BLANK_COLOUR)  ? blank_ff :
      hit(i_araddr, lsi_pkg::IDX_REMOTE_STATE)  ? state_view :
      hit(i_araddr, lsi_pkg::IDX_REMOTE_TARGET) ? target_ff :
      hit(i_araddr, lsi_pkg::IDX_REMOTE_OFFSET) ? offset_ff :
      hit(i_araddr, lsi_pkg::IDX_REMOTE_DATA)   ? data_ff : 8'h00;
  wire rd_mapped = hit(i_araddr, lsi_pkg::IDX_IRQ_ENABLE)
                || hit(i_araddr, lsi_pkg::IDX_IRQ_FLAGS)
                || hit(i_araddr, lsi_pkg::IDX_KEYSTORE_CTRL)
                || hit(i_araddr, lsi_pkg::IDX_LINK_OPTIONS)
                || hit(i_araddr, lsi_pkg::IDX_BLANK_COLOUR)
                || hit(i_araddr, lsi_pkg::IDX_REMOTE_STATE)
                || hit(i_araddr, lsi_pkg::IDX_REMOTE_TARGET)
                || hit(i_araddr, lsi_pkg::IDX_REMOTE_OFFSET)
                || hit(i_araddr, lsi_pkg::IDX_REMOTE_DATA);

  // Idle timer limit follows the speedup bit live
  wire [CNT_W-1:0] idle_limit = remote_ctl_ff[lsi_pkg::BIT_TO_SPEEDUP]
                              ? CNT_W'(lsi_pkg::SPEEDUP_CYCLES)           // see R16
                              : CNT_W'(IDLE_CYCLES);                      // see R15
  wire idle_hold = i_bus_activity || remote_ctl_ff[lsi_pkg::BIT_TO_DISABLE] || master_rst_ff;

  assign o_awready             = wr_take;
  assign o_wready              = wr_take;
  assign o_bvalid              = bvalid_ff;
  assign o_bresp               = bresp_ff;
  assign o_arready             = rd_take;
  assign o_rvalid              = rvalid_ff;
  assign o_rdata               = rdata_ff;
  assign o_rresp               = rresp_ff;
  assign o_irq                 = irq_en_ff[lsi_pkg::BIT_GLOBAL] && any_enabled; // see R01
  assign o_keystore_check_req  = check_req_ff;
  assign o_blue_channel        = blue_ff;
  assign o_remote_start        = start_ff;
  assign o_remote_target_addr  = target_ff[7:1];                          // see R20
  assign o_remote_dir_sel      = target_ff[0];
  assign o_remote_offset       = offset_ff;
  assign o_remote_data_byte    = data_ff;
  assign o_remote_master_reset = master_rst_ff;
  assign o_fast_mode           = remote_ctl_ff[lsi_pkg::BIT_FAST_MODE];   // see R17
  assign o_idle_bus_free       = (idle_cnt_ff >= idle_limit);             // see R15

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= lsi_pkg::RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= lsi_pkg::RESP_OKAY;
    end else begin
      if (wr_take) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_mapped ? lsi_pkg::RESP_OKAY : lsi_pkg::RESP_SLVERR;
      end else if (i_bready) begin
        bvalid_ff <= 1'b0;
      end
      if (rd_take) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= {24'h00_0000, rd_byte};
        rresp_ff  <= rd_mapped ? lsi_pkg::RESP_OKAY : lsi_pkg::RESP_SLVERR;
      end else if (i_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_en_ff    <= lsi_pkg::RST_ZERO;
      flags_ff     <= 7'h00;
      auth_ok_q_ff <= 1'b0;
      wait_lock_ff <= 1'b0;
      blank_ff     <= lsi_pkg::RST_BLANK;
      blue_ff      <= lsi_pkg::RST_ZERO;
    end else begin
      auth_ok_q_ff <= i_auth_ok;
      flags_ff     <= nxt_flags;
      if (wr_en) irq_en_ff <= wbyte;
      if (wr_opt) wait_lock_ff <= wbyte[lsi_pkg::BIT_WAIT_LOCK];
      if (wr_blank) blank_ff <= wbyte;
      blue_ff <= i_blank_screen ? blank_ff : i_video_blue;               // see R13
    end
  end

  // Key-store check: start bit stays up until the checker reports back
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      keystore_ff  <= lsi_pkg::RST_ZERO;
      check_req_ff <= 1'b0;
    end else begin
      check_req_ff <= check_begin;
      if (wr_key) begin
        keystore_ff <= (keystore_ff & ~lsi_pkg::KEYSTORE_RW_MASK)
                     | (wbyte & lsi_pkg::KEYSTORE_RW_MASK);
      end
      if (check_begin) begin
        keystore_ff[lsi_pkg::BIT_CHECK_START] <= 1'b1;
        keystore_ff[lsi_pkg::BIT_CHECK_DONE]  <= 1'b0;
      end
      if (i_keystore_check_finish && keystore_ff[lsi_pkg::BIT_CHECK_START]) begin
        keystore_ff[lsi_pkg::BIT_CHECK_START] <= 1'b0;                    // see R10
        keystore_ff[lsi_pkg::BIT_CHECK_DONE]  <= 1'b1;                    // see R11
        keystore_ff[lsi_pkg::BIT_CHECK_OK]    <= i_keystore_check_match;  // see R12
      end
    end
  end

  // Remote access: a finish landing with a read of the state keeps the bit set
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      remote_ctl_ff <= lsi_pkg::RST_ZERO;
      master_rst_ff <= 1'b0;
      start_ff      <= 1'b0;
      finished_ff   <= 1'b0;
      acked_ff      <= 1'b0;
      target_ff     <= lsi_pkg::RST_ZERO;
      offset_ff     <= lsi_pkg::RST_ZERO;
      data_ff       <= lsi_pkg::RST_ZERO;
      idle_cnt_ff   <= '0;
    end else begin
      start_ff      <= wr_target;                                         // see R23
      master_rst_ff <= wr_state && wbyte[lsi_pkg::BIT_MASTER_RST];        // see R14
      if (wr_state) remote_ctl_ff <= wbyte & lsi_pkg::REMOTE_CTL_MASK;
      if (wr_target) target_ff <= wbyte;
      if (wr_offset) offset_ff <= wbyte;
      if (i_remote_finish) begin
        finished_ff <= 1'b1;                                              // see R19
        acked_ff    <= i_remote_acked;                                    // see R18
      end else begin
        if (rd_state || wr_target) finished_ff <= 1'b0;                   // see R19
        if (wr_target) acked_ff <= 1'b0;                                  // see R23
      end
      // A software write landing with a write-access finish must not be lost
      if (i_remote_finish && target_ff[0] && i_remote_acked) begin
        data_ff <= i_remote_rdata;                                        // see R21
      end else if (wr_data) begin
        data_ff <= wbyte;                                                 // see R21
      end
      if (idle_hold) idle_cnt_ff <= '0;
      else if (idle_cnt_ff < idle_limit) idle_cnt_ff <= idle_cnt_ff + CNT_W'(1);
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_irq_global_gate: assert property (o_irq |-> irq_en_ff[0]) // see R01
    else $error("Interrupt raised without global enable");
  a_global_flag_any: assert property ( // see R02
      ((i_sink_irq && irq_en_ff[5]) || (i_remote_finish && irq_en_ff[7])) && !wr_en
      |=> flags_view[0])
    else $error("Global flag missing for enabled event");
  a_access_done_flag: assert property (i_remote_finish |=> flags_ff[7] && finished_ff) // see R03
    else $error("Completion not flagged");
  a_detect_waits_lock: assert property ( // see R04
      wait_lock_ff && !i_sink_lock && rd_flags |=> !flags_ff[6])
    else $error("Detect flag set before lock");
  a_auth_loss_flag: assert property ($fell(i_auth_ok) |=> flags_ff[2]) // see R08
    else $error("Loss of authentication not flagged");
  a_flag_read_clear: assert property ( // see R22
      rd_flags && !i_key_list_ready ##1 !i_key_list_ready |-> !flags_ff[4])
    else $error("Flag survived read with no condition");
  a_check_complete: assert property ( // see R10
      keystore_ff[2] && i_keystore_check_finish
      |=> !keystore_ff[2] && keystore_ff[6]
          && keystore_ff[7] == $past(i_keystore_check_match))
    else $error("Key check did not complete properly");
  a_blue_substitute: assert property ( // see R13
      i_blank_screen |=> o_blue_channel == $past(blank_ff))
    else $error("Blue channel not substituted");
  a_master_reset_pulse: assert property ( // see R14
      wr_state && wbyte[7] |=> o_remote_master_reset ##1 !o_remote_master_reset
      || $past(wr_state && wbyte[7]))
    else $error("Master reset not a pulse");
  a_finished_clear: assert property ( // see R19
      finished_ff && rd_state && !i_remote_finish |=> !finished_ff)
    else $error("Finished bit not cleared on read");
  a_idle_speedup: assert property ( // see R16
      (remote_ctl_ff[6] && !remote_ctl_ff[5] && !$past(master_rst_ff) && !i_bus_activity)
      [*8] |-> idle_cnt_ff != '0)
    else $error("Idle timer not counting");

  c_remote_read: cover property (start_ff ##[1:50] i_remote_finish && target_ff[0]);
  c_irq_raised:  cover property ($rose(o_irq));
  c_check_done:  cover property ($rose(keystore_ff[6]));
  c_bus_free:    cover property ($rose(o_idle_bus_free));

endmodule : lsi_top
`default_nettype wire

// >>> verif/lsi_remote_model.sv
`timescale 1ns/1ps
`default_nettype none
module lsi_remote_model #(
  parameter logic [7:0] READ_BYTE = 8'ha7
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_start,
  input  wire logic       i_master_reset,
  input  wire logic [3:0] i_delay,
  input  wire logic       i_nack,
  output logic            o_finish,
  output logic            o_acked,
  output logic [7:0]      o_rdata
);
  logic [4:0] cnt_ff;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_ff   <= 5'h00;
      o_finish <= 1'b0;
      o_acked  <= 1'b0;
      o_rdata  <= 8'h00;
    end else begin
      // Ack and data mean nothing away from finish, so they churn there
      o_finish <= 1'b0;
      o_acked  <= ~o_acked;
      o_rdata  <= ~o_rdata;
      if (i_master_reset) begin
        cnt_ff <= 5'h00;
      end else if (i_start) begin
        cnt_ff <= {1'b0, i_delay} + 5'h02;
      end else if (cnt_ff != 5'h00) begin
        cnt_ff <= cnt_ff - 5'h01;
      end
      if (cnt_ff == 5'h01 && !i_master_reset) begin
        o_finish <= 1'b1;
        o_acked  <= !i_nack;
        o_rdata  <= READ_BYTE;
      end
    end
  end
endmodule : lsi_remote_model
`default_nettype wire

// >>> verif/link_security_irq_and_indirect_access_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module link_security_irq_and_indirect_access_test;
  localparam int         IDLE = 2000;
  localparam logic [7:0] RB   = 8'ha7;
  logic        clk, rst_b, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, irq, kreq, kfin, kmatch, lock, blank, start;
  logic        dir, mrst, fast, fin, ack, act, free, nack;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [7:0]  ev, vblue, blue, offs, dbyte, prd, en, f, d, m;
  logic [6:0]  taddr;
  logic [3:0]  dly;
  logic [33:0] expq[$];
  logic [33:0] exp_rd;
  int          mismatches = 0, num_checks = 0, seed = 18, starts = 0, kreqs = 0, mrsts = 0;
  int          lim;

  lsi_top #(.IDLE_CYCLES(IDLE)) uut (.i_clk(clk), .i_rst_b(rst_b),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .o_irq(irq), .i_sink_detect(ev[6]), .i_sink_lock(lock),
    .i_sink_irq(ev[5]), .i_key_list_ready(ev[4]), .i_sink_key_ready(ev[3]),
    .i_auth_ok(ev[1]), .i_auth_fail(ev[2]), .o_keystore_check_req(kreq),
    .i_keystore_check_finish(kfin), .i_keystore_check_match(kmatch),
    .i_blank_screen(blank), .i_video_blue(vblue), .o_blue_channel(blue),
    .o_remote_start(start), .o_remote_target_addr(taddr), .o_remote_dir_sel(dir),
    .o_remote_offset(offs), .o_remote_data_byte(dbyte), .i_remote_finish(fin),
    .i_remote_acked(ack), .i_remote_rdata(prd), .o_remote_master_reset(mrst),
    .o_fast_mode(fast), .i_bus_activity(act), .o_idle_bus_free(free));

  lsi_remote_model #(.READ_BYTE(RB)) partner (.i_clk(clk), .i_rst_b(rst_b),
    .i_start(start), .i_master_reset(mrst), .i_delay(dly), .i_nack(nack),
    .o_finish(fin), .o_acked(ack), .o_rdata(prd));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    starts += int'(start);
    kreqs  += int'(kreq);
    mrsts  += int'(mrst);
    if (rvalid && rready) begin
      // Pop once: the macro evaluates its expected argument twice
      exp_rd = expq.pop_front();
      `CHK({rresp, rdata}, exp_rd)
    end
  end

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Every wait is bounded; running out ends the run as a failure
  task automatic waitfor(ref logic s, input int bound);
    for (int n = 0; n < bound; n++) begin
      @(posedge clk);
      if (s === 1'b1) return;
    end
    mismatches++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    conclude();
  endtask : waitfor

  task automatic wr(input logic [7:0] idx, input logic [7:0] v, input logic [1:0] er = 2'b00);
    logic a, w;
    a = 1'b0;
    w = 1'b0;
    awaddr  <= {2'b00, idx, 2'b00};
    wdata   <= {24'($random(seed)), v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; !(a && w); n++) begin
      @(posedge clk);
      if (awready) begin a = 1'b1; awvalid <= 1'b0; end
      if (wready) begin w = 1'b1; wvalid <= 1'b0; end
      if (n > 50) waitfor(a, 0);
    end
    waitfor(bvalid, 50);
    `CHK(bresp, er)
    bready <= 1'b0;
    // Let an edge pass so a following call never re-raises ready in this step
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er = 2'b00);
    expq.push_back({er, 24'h0, e});
    araddr  <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    waitfor(arready, 50);
    arvalid <= 1'b0;
    waitfor(rvalid, 50);
    rready  <= 1'b0;
    @(posedge clk);
  endtask : rd

  function automatic logic [7:0] fl(input logic [7:0] x);
    return {x[7:1], |(x[7:1] & en[7:1])};
  endfunction : fl

  initial begin
    rst_b = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, kfin, kmatch, lock, blank, act, nack} = '0;
    {awaddr, araddr, wdata, ev, vblue, dly, en} = '0;
    cyc(12);
    rst_b <= 1'b1;
    cyc(1);
    rd(lsi_pkg::IDX_IRQ_ENABLE, 8'h00);
    rd(lsi_pkg::IDX_IRQ_FLAGS, 8'h00);
    rd(lsi_pkg::IDX_KEYSTORE_CTRL, 8'h00);
    rd(lsi_pkg::IDX_BLANK_COLOUR, 8'hff);
    rd(lsi_pkg::IDX_REMOTE_STATE, 8'h00);
    rd(8'h10, 8'h00, lsi_pkg::RESP_SLVERR);
    wr(8'h10, 8'h5a, lsi_pkg::RESP_SLVERR);
    $display("test reset values done");
    for (int b = 1; b < 7; b++) begin
      en = 8'($random(seed));
      wr(lsi_pkg::IDX_IRQ_ENABLE, en);
      ev[b] <= 1'b1;
      cyc(3);
      f = fl(8'h01 << b);
      `CHK(irq, en[0] & f[0])
      rd(lsi_pkg::IDX_IRQ_FLAGS, f);
      ev[b] <= 1'b0;
      cyc(3);
      rd(lsi_pkg::IDX_IRQ_FLAGS, fl((8'h01 << b) | (b == 1 ? 8'h04 : 8'h00)));
      rd(lsi_pkg::IDX_IRQ_FLAGS, fl(8'h00));
    end
    wr(lsi_pkg::IDX_LINK_OPTIONS, 8'h01);
    ev[6] <= 1'b1;
    cyc(3);
    rd(lsi_pkg::IDX_IRQ_FLAGS, fl(8'h00));
    lock <= 1'b1;
    cyc(3);
    {ev[6], lock} <= 2'b00;
    cyc(3);
    rd(lsi_pkg::IDX_IRQ_FLAGS, fl(8'h40));
    $display("test events done");
    en = 8'h81;
    wr(lsi_pkg::IDX_IRQ_ENABLE, en);
    for (int k = 0; k < 3; k++) begin
      nack <= (k == 2);
      dly  <= 4'($random(seed));
      wr(lsi_pkg::IDX_REMOTE_DATA, 8'h3c);
      wr(lsi_pkg::IDX_REMOTE_OFFSET, 8'h11 + 8'(k));
      wr(lsi_pkg::IDX_REMOTE_TARGET, {7'h2a, k != 0});
      waitfor(fin, 100);
      cyc(2);
      d = (k == 1) ? RB : 8'h3c;
      `CHK({taddr, dir, offs}, {7'h2a, k != 0, 8'h11 + 8'(k)})
      `CHK(dbyte, d)
      `CHK(irq, 1'b1)
      `CHK(starts, k + 1)
      rd(lsi_pkg::IDX_REMOTE_STATE, {6'h00, k != 2, 1'b1});
      rd(lsi_pkg::IDX_REMOTE_STATE, {6'h00, k != 2, 1'b0});
      rd(lsi_pkg::IDX_REMOTE_DATA, d);
      rd(lsi_pkg::IDX_IRQ_FLAGS, fl(8'h80));
    end
    $display("test remote access done");
    wr(lsi_pkg::IDX_REMOTE_STATE, 8'hf0);
    cyc(2);
    `CHK(mrsts, 1)
    `CHK(fast, 1'b1)
    rd(lsi_pkg::IDX_REMOTE_STATE, 8'h70);
    for (int i = 0; i < 3; i++) begin
      m   = (i == 0) ? 8'h20 : (i == 1) ? 8'h40 : 8'h00;
      lim = (i == 1) ? lsi_pkg::SPEEDUP_CYCLES : IDLE;
      wr(lsi_pkg::IDX_REMOTE_STATE, m);
      act <= 1'b1;
      cyc(1);
      act <= 1'b0;
      cyc(lim - 20);
      `CHK(free, 1'b0)
      cyc(40);
      `CHK(free, i != 0)
    end
    `CHK(fast, 1'b0)
    $display("test remote control done");
    for (int k = 0; k < 2; k++) begin
      wr(lsi_pkg::IDX_KEYSTORE_CTRL, 8'h04);
      cyc(2);
      rd(lsi_pkg::IDX_KEYSTORE_CTRL, 8'h04);
      `CHK(kreqs, k + 1)
      kmatch <= k[0];
      kfin   <= 1'b1;
      cyc(1);
      kfin   <= 1'b0;
      cyc(2);
      rd(lsi_pkg::IDX_KEYSTORE_CTRL, {k[0], 7'h40});
    end
    $display("test key check done");
    f = 8'($random(seed));
    wr(lsi_pkg::IDX_BLANK_COLOUR, f);
    blank <= 1'b1;
    vblue <= ~f;
    cyc(2);
    `CHK(blue, f)
    blank <= 1'b0;
    cyc(2);
    `CHK(blue, ~f)
    $display("test blank colour done");
    conclude();
  end
endmodule : link_security_irq_and_indirect_access_test
`default_nettype wire
